/* hdl/annun_pkg.sv */
package annun_pkg;
    // ========================================
    // panel geometry
    localparam int NUM_RELAYS = 4;
    localparam int NUM_LAMPS = 21;
    localparam int NUM_INPUTS = 20;
    // ========================================
    // lamp colour codes
    localparam logic [1:0] COLOR_OFF = 2'h0;
    localparam logic [1:0] COLOR_GREEN = 2'h1;
    localparam logic [1:0] COLOR_AMBER = 2'h2;
    localparam logic [1:0] COLOR_RED = 2'h3;
    // ========================================
    // timing, clock at 100 MHz
    localparam int CLK_HZ = 100_000_000;
    localparam int HEARTBEAT_MS = 500;
    localparam int HEARTBEAT_CYC = CLK_HZ / 1000 * HEARTBEAT_MS;
    localparam int STEP_MS = 500;
    localparam int STEP_CYC = CLK_HZ / 1000 * STEP_MS;
    localparam int BCAST_MS = 5000;
    localparam int BCAST_CYC = CLK_HZ / 1000 * BCAST_MS;
    localparam int HOLD_MS = 2000;
    localparam int HOLD_CYC = CLK_HZ / 1000 * HOLD_MS;
    localparam int DEBOUNCE_MS = 20;
    localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
    // ========================================
    // panel sequencer states
    typedef enum logic [2:0] {
        ST_SELF_GREEN = 3'b000,
        ST_SELF_AMBER = 3'b001,
        ST_SELF_RED = 3'b010,
        ST_RUN = 3'b011,
        ST_TEST_BRIEF = 3'b100,
        ST_TEST_GREEN = 3'b101,
        ST_TEST_AMBER = 3'b110,
        ST_TEST_RED = 3'b111
    } panel_state_type;
endpackage : annun_pkg

/* hdl/annunciator_panel.sv */
`timescale 1ns/10ps
`default_nettype none
module annunciator_panel
    import annun_pkg::*;
#(
    parameter int STEP_CYCLES = STEP_CYC,
    parameter int HEARTBEAT_CYCLES = HEARTBEAT_CYC,
    parameter int BCAST_CYCLES = BCAST_CYC,
    parameter int HOLD_CYCLES = HOLD_CYC,
    parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic relay_cmd_valid,
    input wire logic [1:0] relay_cmd_index,
    input wire logic relay_cmd_on,
    input wire logic link_up,
    input wire logic [NUM_INPUTS-1:0] wired_in_raw,
    input wire logic [NUM_INPUTS-1:0] net_in,
    input wire logic polarity_positive,
    input wire logic cfg_write,
    input wire logic [4:0] cfg_lamp,
    input wire logic [1:0] cfg_color,
    input wire logic local_button,
    input wire logic shared_silence_terminal_in,
    output logic shared_silence_terminal_out,
    output logic shared_silence_terminal_oe,
    output logic [NUM_RELAYS-1:0] relay_contact_header,
    output logic run_heartbeat_led,
    output logic [1:0] network_status_lamp,
    output logic [2*NUM_INPUTS-1:0] lamp_color,
    output logic horn_silence,
    output logic status_bcast,
    output logic [NUM_INPUTS-1:0] status_word
);
    // ========================================
    // helpers
    function automatic logic [2*NUM_INPUTS-1:0] fill(input logic [1:0] c);
        fill = {NUM_INPUTS{c}};
    endfunction : fill

    panel_state_type state_r, state_nxt;
    logic [31:0] step_cnt_r, hb_cnt_r, bc_cnt_r, hold_cnt_r;
    logic [2*NUM_INPUTS-1:0] cfg_r;
    logic [NUM_INPUTS-1:0] wired_prev_r;
    logic silence_clean, button_clean, step_done, hold_done;
    logic [NUM_INPUTS-1:0] wired_active, lamp_on;
    logic [2*NUM_INPUTS-1:0] shown_cfg, lamp_nxt;

    // ========================================
    // input conditioning
    assign wired_active = polarity_positive ? wired_in_raw
                                            : ~wired_in_raw;
    assign lamp_on = wired_active | net_in;
    assign step_done = step_cnt_r >= 32'(STEP_CYCLES - 1);
    assign hold_done = hold_cnt_r >= 32'(HOLD_CYCLES - 1);

    level_debounce #(.STABLE_CYC(DEBOUNCE_CYCLES)) u_sil_db (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .raw_in(shared_silence_terminal_in),
        .clean_out(silence_clean)
    );
    level_debounce #(.STABLE_CYC(DEBOUNCE_CYCLES)) u_btn_db (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .raw_in(local_button),
        .clean_out(button_clean)
    );

    genvar g;
    generate
        for (g = 0; g < NUM_INPUTS; g++) begin : g_show
            assign shown_cfg[2*g +: 2] = lamp_on[g] ? cfg_r[2*g +: 2]
                                                    : COLOR_OFF;
        end
    endgenerate

    // ========================================
    // panel sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_SELF_GREEN: if (step_done) state_nxt = ST_SELF_AMBER;
            ST_SELF_AMBER: if (step_done) state_nxt = ST_SELF_RED;
            ST_SELF_RED: if (step_done) state_nxt = ST_RUN;
            ST_RUN: if (button_clean) state_nxt = ST_TEST_BRIEF;
            ST_TEST_BRIEF: begin
                if (!button_clean) state_nxt = ST_RUN;
                else if (hold_done) state_nxt = ST_TEST_GREEN;
            end
            ST_TEST_GREEN: if (step_done) state_nxt = ST_TEST_AMBER;
            ST_TEST_AMBER: if (step_done) state_nxt = ST_TEST_RED;
            ST_TEST_RED: if (step_done) state_nxt = ST_RUN;
            default: state_nxt = ST_RUN;
        endcase
    end

    always_comb begin
        case (state_r)
            ST_SELF_GREEN, ST_TEST_GREEN, ST_TEST_BRIEF:
                lamp_nxt = fill(COLOR_GREEN);
            ST_SELF_AMBER, ST_TEST_AMBER: lamp_nxt = fill(COLOR_AMBER);
            ST_SELF_RED, ST_TEST_RED: lamp_nxt = fill(COLOR_RED);
            default: lamp_nxt = shown_cfg;
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_SELF_GREEN;
            step_cnt_r <= 32'h0;
            hold_cnt_r <= 32'h0;
        end else begin
            state_r <= state_nxt;
            step_cnt_r <= (state_nxt != state_r) ? 32'h0
                                                  : step_cnt_r + 32'h1;
            hold_cnt_r <= (state_r == ST_TEST_BRIEF) ? hold_cnt_r + 32'h1
                                                     : 32'h0;
        end
    end

    // ========================================
    // configuration, factory default all red
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_r <= {NUM_INPUTS{COLOR_RED}};
        end else if (cfg_write && cfg_lamp < 5'(NUM_INPUTS)) begin
            cfg_r[2*cfg_lamp +: 2] <= cfg_color;
        end
    end

    // ========================================
    // relays, heartbeat, network, silence
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            relay_contact_header <= '0;
            hb_cnt_r <= 32'h0;
            run_heartbeat_led <= 1'b0;
            network_status_lamp <= COLOR_OFF;
            lamp_color <= '0;
            horn_silence <= 1'b0;
            shared_silence_terminal_out <= 1'b0;
            shared_silence_terminal_oe <= 1'b0;
        end else begin
            if (relay_cmd_valid) begin
                relay_contact_header[relay_cmd_index] <= relay_cmd_on;
            end
            if (state_r == ST_SELF_GREEN || state_r == ST_SELF_AMBER ||
                state_r == ST_SELF_RED) begin
                hb_cnt_r <= 32'h0;
                run_heartbeat_led <= 1'b0;
            end else if (hb_cnt_r >= 32'(HEARTBEAT_CYCLES - 1)) begin
                hb_cnt_r <= 32'h0;
                run_heartbeat_led <= ~run_heartbeat_led;
            end else begin
                hb_cnt_r <= hb_cnt_r + 32'h1;
            end
            network_status_lamp <= link_up ? COLOR_GREEN : COLOR_OFF;
            lamp_color <= lamp_nxt;
            // open-drain style: pull the shared line only while pressed
            shared_silence_terminal_out <= 1'b1;
            shared_silence_terminal_oe <= button_clean;
            horn_silence <= silence_clean | button_clean;
        end
    end

    // ========================================
    // status broadcast
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wired_prev_r <= '0;
            bc_cnt_r <= 32'h0;
            status_bcast <= 1'b0;
            status_word <= '0;
        end else begin
            wired_prev_r <= wired_active;
            status_word <= wired_active;
            if (wired_active != wired_prev_r ||
                bc_cnt_r >= 32'(BCAST_CYCLES - 1)) begin
                status_bcast <= 1'b1;
                bc_cnt_r <= 32'h0;
            end else begin
                status_bcast <= 1'b0;
                bc_cnt_r <= bc_cnt_r + 32'h1;
            end
        end
    end

    // ========================================
    // checks
    property p_relay_follows;
        @(posedge ref_clk) disable iff (sys_rst)
        relay_cmd_valid |=> relay_contact_header[$past(relay_cmd_index)]
                            == $past(relay_cmd_on);
    endproperty
    a_relay_follows: assert property (p_relay_follows)
        else $error("relay did not follow command");
    property p_relay_hold;
        @(posedge ref_clk) disable iff (sys_rst)
        !relay_cmd_valid |=> $stable(relay_contact_header);
    endproperty
    a_relay_hold: assert property (p_relay_hold)
        else $error("relay changed without command");
    property p_self_seq;
        @(posedge ref_clk) disable iff (sys_rst)
        (state_r == ST_SELF_GREEN && step_done) |=> state_r == ST_SELF_AMBER;
    endproperty
    a_self_seq: assert property (p_self_seq)
        else $error("self cycle order wrong");
    property p_hb_idle;
        @(posedge ref_clk) disable iff (sys_rst)
        state_r == ST_SELF_RED |=> !run_heartbeat_led;
    endproperty
    a_hb_idle: assert property (p_hb_idle)
        else $error("heartbeat before running mode");
    property p_net_lamp;
        @(posedge ref_clk) disable iff (sys_rst)
        link_up |=> network_status_lamp == COLOR_GREEN;
    endproperty
    a_net_lamp: assert property (p_net_lamp)
        else $error("network lamp not green");
    property p_silence;
        @(posedge ref_clk) disable iff (sys_rst)
        silence_clean |=> horn_silence;
    endproperty
    a_silence: assert property (p_silence)
        else $error("shared silence ignored");
    property p_brief_green;
        @(posedge ref_clk) disable iff (sys_rst)
        state_r == ST_TEST_BRIEF |=> lamp_color == fill(COLOR_GREEN);
    endproperty
    a_brief_green: assert property (p_brief_green)
        else $error("lamp test not green");
    property p_hold_red;
        @(posedge ref_clk) disable iff (sys_rst)
        state_r == ST_TEST_AMBER && step_done |=> state_r == ST_TEST_RED;
    endproperty
    a_hold_red: assert property (p_hold_red)
        else $error("held test order wrong");
    property p_bcast_change;
        @(posedge ref_clk) disable iff (sys_rst)
        wired_active != wired_prev_r |=> status_bcast;
    endproperty
    a_bcast_change: assert property (p_bcast_change)
        else $error("no broadcast on input change");
    property p_lamp_or;
        @(posedge ref_clk) disable iff (sys_rst)
        state_r == ST_RUN && lamp_on == '0 && state_nxt == ST_RUN
            |=> lamp_color == '0;
    endproperty
    a_lamp_or: assert property (p_lamp_or)
        else $error("lamp lit with all inputs off");
    c_brief: cover property (@(posedge ref_clk) state_r == ST_TEST_BRIEF
        ##1 state_r == ST_RUN);
    c_held: cover property (@(posedge ref_clk) state_r == ST_TEST_RED);
    c_relay: cover property (@(posedge ref_clk) relay_cmd_valid);
endmodule : annunciator_panel
`default_nettype wire

/* hdl/level_debounce.sv */
`timescale 1ns/10ps
`default_nettype none
module level_debounce #(
    parameter int STABLE_CYC = 2000000
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic raw_in,
    output logic clean_out
);
    logic [31:0] cnt_r;
    logic last_r;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= 32'h0;
            last_r <= 1'b0;
            clean_out <= 1'b0;
        end else if (raw_in != last_r) begin
            last_r <= raw_in;
            cnt_r <= 32'h0;
        end else if (cnt_r >= 32'(STABLE_CYC - 1)) begin
            clean_out <= last_r;
        end else begin
            cnt_r <= cnt_r + 32'h1;
        end
    end
endmodule : level_debounce
`default_nettype wire

/* testbench/annunciator_lamp_relay_control_tb.sv */
`timescale 1ns/10ps
`default_nettype none
// ========================================
// panel bench
module annunciator_lamp_relay_control_tb
    import annun_pkg::*;
;
    localparam int STEP = 8;
    localparam int HB = 4;
    localparam int BC = 16;
    localparam int HOLD = 10;
    localparam int DEB = 3;
    localparam logic [39:0] ALL_G = {NUM_INPUTS{COLOR_GREEN}};
    localparam logic [39:0] ALL_A = {NUM_INPUTS{COLOR_AMBER}};
    localparam logic [39:0] ALL_R = {NUM_INPUTS{COLOR_RED}};
    logic ref_clk, sys_rst, cmd_valid, cmd_on, link_up, pol_pos, cfg_write;
    logic [1:0] cmd_idx, cfg_color, net_lamp;
    logic [4:0] cfg_lamp;
    logic [NUM_INPUTS-1:0] wired_raw, net_in, status_word;
    logic local_button, remote_silence, sil_in, sil_out, sil_oe;
    logic hb_led, horn, bcast;
    logic [NUM_RELAYS-1:0] relays;
    logic [2*NUM_INPUTS-1:0] lamps;
    int fails = 0;
    int n_compared = 0;
    int cyc = 0;
    // shared line: our driver when enabled, or another panel
    assign sil_in = (sil_oe & sil_out) | remote_silence;
    genset_ctrl_model partner (.ref_clk(ref_clk), .relay_cmd_valid(cmd_valid),
        .relay_cmd_index(cmd_idx), .relay_cmd_on(cmd_on),
        .link_up(link_up), .net_in(net_in));
    annunciator_panel #(.STEP_CYCLES(STEP), .HEARTBEAT_CYCLES(HB),
        .BCAST_CYCLES(BC), .HOLD_CYCLES(HOLD), .DEBOUNCE_CYCLES(DEB)) dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .relay_cmd_valid(cmd_valid),
        .relay_cmd_index(cmd_idx), .relay_cmd_on(cmd_on), .link_up(link_up),
        .wired_in_raw(wired_raw), .net_in(net_in),
        .polarity_positive(pol_pos), .cfg_write(cfg_write),
        .cfg_lamp(cfg_lamp), .cfg_color(cfg_color),
        .local_button(local_button), .shared_silence_terminal_in(sil_in),
        .shared_silence_terminal_out(sil_out),
        .shared_silence_terminal_oe(sil_oe), .relay_contact_header(relays),
        .run_heartbeat_led(hb_led), .network_status_lamp(net_lamp),
        .lamp_color(lamps), .horn_silence(horn), .status_bcast(bcast),
        .status_word(status_word));
    // ========================================
    // helpers
    task automatic check(input string what, input logic [39:0] seen,
            input logic [39:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic wait_lamps(input string what, input logic [39:0] exp,
            input int lim);
        int i;
        i = 0;
        while (lamps !== exp && i < lim) begin
            tick(1);
            i++;
        end
        check(what, lamps, exp);
    endtask : wait_lamps
    // sel 0 waits for a broadcast pulse, sel 1 for horn silence
    task automatic wait_bit(input string what, input int sel, input int lim);
        int i;
        i = 0;
        while ((sel == 0 ? bcast : horn) !== 1'b1 && i < lim) begin
            tick(1);
            i++;
        end
        check(what, 40'(sel == 0 ? bcast : horn), 40'h1);
    endtask : wait_bit
    function automatic logic [39:0] lamp_at(input int i, input logic [1:0] c);
        lamp_at = '0;
        lamp_at[2*i +: 2] = c;
    endfunction : lamp_at
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    // ========================================
    // scenarios
    task automatic t_selftest();
        check("relays after reset", 40'(relays), 40'h0);
        wait_lamps("self green", ALL_G, 3);
        wait_lamps("self amber", ALL_A, STEP + 3);
        wait_lamps("self red", ALL_R, STEP + 3);
        wait_lamps("run idle", 40'h0, STEP + 3);
        $display("test selftest done");
    endtask : t_selftest
    task automatic t_heartbeat();
        int n;
        logic prev;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            prev = hb_led;
            while (hb_led === prev && n < 4 * HB) begin
                tick(1);
                n++;
            end
        end
        check("heartbeat half period", 40'(n), 40'(HB));
        $display("test heartbeat done");
    endtask : t_heartbeat
    task automatic t_relays();
        for (int i = 0; i < NUM_RELAYS; i++) partner.send(2'(i), 1'b1);
        partner.idle(0);
        tick(1);
        check("all relays on", 40'(relays), 40'hF);
        partner.send(2'h2, 1'b0);
        partner.idle(6);
        #1;
        check("relay 2 off", 40'(relays), 40'hB);
        partner.send(2'h2, 1'b0);
        partner.send(2'h0, 1'b0);
        partner.send(2'h3, 1'b0);
        partner.idle(1);
        #1;
        check("relays 0 3 off", 40'(relays), 40'h2);
        $display("test relays done");
    endtask : t_relays
    task automatic t_lamps();
        partner.set_net(1'b1, 20'h00001);
        tick(3);
        check("network lamp", 40'(net_lamp), 40'(COLOR_GREEN));
        wait_lamps("net input", lamp_at(0, COLOR_RED), 4);
        @(posedge ref_clk);
        wired_raw <= ~20'h00008;
        // exact edge, so a periodic pulse cannot stand in for the change pulse
        tick(1);
        check("bcast on change", 40'(bcast), 40'h1);
        check("status word", 40'(status_word), 40'h8);
        wait_lamps("low wired", lamp_at(0, COLOR_RED) | lamp_at(3, COLOR_RED),
            DEB + 6);
        @(posedge ref_clk);
        pol_pos <= 1'b1;
        wired_raw <= 20'h00020;
        wait_lamps("high wired", lamp_at(0, COLOR_RED) | lamp_at(5, COLOR_RED),
            DEB + 6);
        @(posedge ref_clk);
        cfg_write <= 1'b1;
        cfg_lamp <= 5'h00;
        cfg_color <= COLOR_AMBER;
        @(posedge ref_clk);
        cfg_write <= 1'b0;
        wait_lamps("cfg colour", lamp_at(0, COLOR_AMBER) |
            lamp_at(5, COLOR_RED), 4);
        wait_bit("bcast first", 0, BC + 2);
        tick(1);
        wait_bit("bcast periodic", 0, BC + 2);
        partner.set_net(1'b1, 20'h0);
        wired_raw <= 20'h0;
        wait_lamps("inputs clear", 40'h0, DEB + 6);
        $display("test lamps done");
    endtask : t_lamps
    task automatic t_silence();
        @(posedge ref_clk);
        local_button <= 1'b1;
        wait_lamps("brief test", ALL_G, DEB + 4);
        wait_bit("local silence", 1, 3);
        check("line driven", 40'(sil_oe & sil_out), 40'h1);
        @(posedge ref_clk);
        local_button <= 1'b0;
        wait_lamps("after brief", 40'h0, 60);
        // let the local silence drain so the remote check starts from quiet
        tick(DEB + 4);
        check("horn released", 40'(horn), 40'h0);
        @(posedge ref_clk);
        remote_silence <= 1'b1;
        wait_bit("remote silence", 1, DEB + 4);
        tick(DEB + 4);
        check("remote no test", lamps, 40'h0);
        check("line not driven", 40'(sil_oe), 40'h0);
        @(posedge ref_clk);
        remote_silence <= 1'b0;
        $display("test silence done");
    endtask : t_silence
    task automatic t_hold();
        // one active lamp so the closing display shows a real setting
        partner.set_net(1'b1, 20'h00001);
        @(posedge ref_clk);
        local_button <= 1'b1;
        wait_lamps("hold green", ALL_G, DEB + 4);
        wait_lamps("hold amber", ALL_A, HOLD + STEP + DEB + 4);
        wait_lamps("hold red", ALL_R, STEP + 4);
        @(posedge ref_clk);
        local_button <= 1'b0;
        wait_lamps("hold config", lamp_at(0, COLOR_AMBER),
            3 * STEP + HOLD + 20);
        $display("test hold done");
    endtask : t_hold
    // ========================================
    // clock, watchdog, sequence
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // ceiling far above the few hundred cycles the tests need
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        sys_rst = 1'b1;
        wired_raw = '1;
        pol_pos = 1'b0;
        cfg_write = 1'b0;
        cfg_lamp = 5'h00;
        cfg_color = COLOR_OFF;
        local_button = 1'b0;
        remote_silence = 1'b0;
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        tick(2);
        t_selftest();
        t_heartbeat();
        t_relays();
        t_lamps();
        t_silence();
        t_hold();
        end_sim();
    end
endmodule : annunciator_lamp_relay_control_tb
`default_nettype wire

/* testbench/genset_ctrl_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ========================================
// far-side controller model
module genset_ctrl_model
    import annun_pkg::*;
(
    input wire logic ref_clk,
    output logic relay_cmd_valid,
    output logic [1:0] relay_cmd_index,
    output logic relay_cmd_on,
    output logic link_up,
    output logic [NUM_INPUTS-1:0] net_in
);
    // one tracked event per relay; an unchanged event sends nothing
    logic [NUM_RELAYS-1:0] event_r = '0;
    initial begin
        relay_cmd_valid = 1'b0;
        relay_cmd_index = 2'h0;
        relay_cmd_on = 1'b0;
        link_up = 1'b0;
        net_in = '0;
    end
    // no release inside, so two calls in a row are back to back
    task automatic send(input logic [1:0] idx, input logic on);
        if (event_r[idx] !== on) begin
            @(posedge ref_clk);
            relay_cmd_valid <= 1'b1;
            relay_cmd_index <= idx;
            relay_cmd_on <= on;
            event_r[idx] = on;
        end
    endtask : send
    // idle lines flip so a stale command never looks live
    task automatic idle(input int gap);
        @(posedge ref_clk);
        relay_cmd_valid <= 1'b0;
        relay_cmd_index <= ~relay_cmd_index;
        relay_cmd_on <= ~relay_cmd_on;
        repeat (gap) @(posedge ref_clk);
    endtask : idle
    task automatic set_net(input logic link, input logic [NUM_INPUTS-1:0] v);
        @(posedge ref_clk);
        link_up <= link;
        net_in <= v;
    endtask : set_net
endmodule : genset_ctrl_model
`default_nettype wire
